// File: cec_consts.svh
// constants for the contact event counter: timing counts, codes and limits
// assumes a 25 MHz system clock; included by the package and every module except cec_server_model
//
// How it works
// (RL1) two inputs, each counted independently
// (RL2) sampling expiry copies live counters to saved
// (RL3) only latest saved value is reported
// (RL4) unchanged saved value suppresses the notification
// (RL5) sampling period 60 to 604800 seconds
// (RL6) activation code selects first, second or both
// (RL7) detection type low, high or both
// (RL8) debounce accepts level persisting beyond period
// (RL9) per input abnormal-time counter enable
// (RL10) push or observe communication mode
// (RL11) counting continues without uplink network
// (RL12) counting continues during transmission
// (RL13) notify after each sampling once observed
// (RL14) evaluation period attributes are ignored
// (RL15) reports never clear; explicit command clears
// (RL16) server observes each wanted counter
// (RL17) server uses one period for both inputs
// (RL18) millisecond and second ticks from clock
`ifndef CEC_CONSTS_SVH
`define CEC_CONSTS_SVH
`define CEC_CLK_HZ 25000000
`define CEC_MS_HZ 1000
`define CEC_MS_CYCLES (`CEC_CLK_HZ / `CEC_MS_HZ)
`define CEC_MS_PER_S 1000
`define CEC_SAMPLE_MIN_S 32'h0000003C
`define CEC_SAMPLE_MAX_S 32'h00093A80
`define CEC_DEB_MIN_MS 32'h0000000A
`define CEC_DEB_MAX_MS 32'h000927C0
`define CEC_ACT_FIRST 2'h1
`define CEC_ACT_SECOND 2'h2
`define CEC_ACT_BOTH 2'h3
`define CEC_DET_LOW 2'h0
`define CEC_DET_HIGH 2'h1
`define CEC_DET_BOTH 2'h2
`define CEC_NUM_INPUTS 2
`endif

// File: cec_pkg.sv
// types for the contact event counter
// assumes cec_consts.svh is on the include path
`default_nettype none
`include "cec_consts.svh"
package cec_pkg;
    typedef enum logic {CEC_MODE_OBSERVE, CEC_MODE_PUSH} cec_mode_t;
    typedef struct packed {
        logic [1:0] det_type;
        logic [31:0] debounce_ms;
        logic time_cnt_en;
        logic abnormal_level;
    } cec_chan_cfg_t;
    typedef struct packed {
        logic [31:0] events;
        logic [31:0] abnormal_s;
    } cec_counts_t;
endpackage
`default_nettype wire

// File: cec_channel.sv
// one contact channel: debounce, edge qualification, event and time counters
// assumes synchronous contact level and one-cycle ms/s tick enables
`timescale 1ns/1ps
`default_nettype none
`include "cec_consts.svh"
module cec_channel
    import cec_pkg::*;
#(
    parameter int CNT_W = 32
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // timebase
    input wire logic ms_tick,
    input wire logic s_tick,
    // control
    input wire logic active,
    input wire cec_chan_cfg_t cfg,
    input wire logic clear,
    // contact
    input wire logic contact,
    // results
    output logic level,
    output cec_counts_t counts
);
    logic stable_reg, stable_next;
    logic [31:0] deb_reg, deb_next;
    logic [CNT_W-1:0] ev_reg, ev_next;
    logic [CNT_W-1:0] tm_reg, tm_next;
    logic accept;
    always_comb begin
        stable_next = stable_reg;
        deb_next = deb_reg;
        ev_next = ev_reg;
        tm_next = tm_reg;
        accept = 1'b0;
        // restart the persistence timer whenever the level bounces back
        if (contact == stable_reg) begin
            deb_next = 32'h00000000;
        end else if (ms_tick) begin
            if (deb_reg >= cfg.debounce_ms) begin // RL8
                stable_next = contact;
                deb_next = 32'h00000000;
                accept = 1'b1;
            end else begin
                deb_next = deb_reg + 32'h00000001;
            end
        end
        if (accept && active) begin // RL1 RL11 RL12
            unique case (cfg.det_type) // RL7
                `CEC_DET_LOW: if (!contact) ev_next = ev_reg + CNT_W'(1);
                `CEC_DET_HIGH: if (contact) ev_next = ev_reg + CNT_W'(1);
                default: ev_next = ev_reg + CNT_W'(1);
            endcase
        end
        if (active && cfg.time_cnt_en && s_tick && stable_reg == cfg.abnormal_level) begin // RL9
            tm_next = tm_reg + CNT_W'(1);
        end
        if (clear) begin // RL15
            ev_next = '0;
            tm_next = '0;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stable_reg <= 1'b0;
            deb_reg <= 32'h00000000;
            ev_reg <= '0;
            tm_reg <= '0;
        end else begin
            stable_reg <= stable_next;
            deb_reg <= deb_next;
            ev_reg <= ev_next;
            tm_reg <= tm_next;
        end
    end
    assign level = stable_reg;
    assign counts.events = 32'(ev_reg);
    assign counts.abnormal_s = 32'(tm_reg);
endmodule
`default_nettype wire

// File: cec_top.sv
// contact event counter top: timebase, sampling period, snapshots, notify
// assumes configuration ports held stable by the management side
`timescale 1ns/1ps
`default_nettype none
`include "cec_consts.svh"
module cec_top
    import cec_pkg::*;
#(
    parameter int MS_CYCLES = `CEC_MS_CYCLES,
    parameter int MS_PER_S = `CEC_MS_PER_S
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // contacts
    input wire logic contact_input_first,
    input wire logic contact_input_second,
    // configuration
    input wire cec_mode_t comm_mode,
    input wire logic [31:0] sample_period_s,
    input wire logic [1:0] active_sel,
    input wire cec_chan_cfg_t cfg_first,
    input wire cec_chan_cfg_t cfg_second,
    input wire logic counters_clear,
    // observation
    input wire logic [3:0] observe_en,
    input wire logic [31:0] epmin_attr,
    input wire logic [31:0] epmax_attr,
    // results
    output logic [1:0] level_out,
    output cec_counts_t saved_first,
    output cec_counts_t saved_second,
    output logic [3:0] notify,
    output logic push_req,
    output logic sample_done
);
    // ------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------
    logic [31:0] div_reg, div_next;
    logic [31:0] msc_reg, msc_next;
    logic ms_tick_reg, ms_tick_next, s_tick_reg, s_tick_next;
    always_comb begin
        div_next = div_reg + 32'h00000001;
        msc_next = msc_reg;
        ms_tick_next = 1'b0;
        s_tick_next = 1'b0;
        if (div_reg >= 32'(MS_CYCLES - 1)) begin // RL18
            div_next = 32'h00000000;
            ms_tick_next = 1'b1;
            msc_next = msc_reg + 32'h00000001;
            if (msc_reg >= 32'(MS_PER_S - 1)) begin
                msc_next = 32'h00000000;
                s_tick_next = 1'b1;
            end
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            div_reg <= 32'h00000000;
            msc_reg <= 32'h00000000;
            ms_tick_reg <= 1'b0;
            s_tick_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            msc_reg <= msc_next;
            ms_tick_reg <= ms_tick_next;
            s_tick_reg <= s_tick_next;
        end
    end
    // ------------------------------------------------------------
    // channels
    // ------------------------------------------------------------
    logic [1:0] act;
    logic [1:0] contact_in;
    logic [1:0] lvl;
    cec_counts_t live [2];
    cec_chan_cfg_t cfgs [2];
    assign act[0] = (active_sel == `CEC_ACT_FIRST) || (active_sel == `CEC_ACT_BOTH); // RL6
    assign act[1] = (active_sel == `CEC_ACT_SECOND) || (active_sel == `CEC_ACT_BOTH); // RL6
    assign contact_in = {contact_input_second, contact_input_first};
    assign cfgs[0] = cfg_first;
    assign cfgs[1] = cfg_second;
    genvar gi;
    generate
        for (gi = 0; gi < `CEC_NUM_INPUTS; gi++) begin : g_ch
            cec_channel #(.CNT_W(32)) u_ch (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .ms_tick(ms_tick_reg),
                .s_tick(s_tick_reg),
                .active(act[gi]),
                .cfg(cfgs[gi]),
                .clear(counters_clear),
                .contact(contact_in[gi]),
                .level(lvl[gi]),
                .counts(live[gi])
            );
        end
    endgenerate
    // ------------------------------------------------------------
    // sampling period
    // ------------------------------------------------------------
    logic [31:0] per_reg, per_next;
    logic [31:0] period_lim;
    logic expire;
    always_comb begin
        // clamp keeps a bad write within the legal range
        period_lim = sample_period_s; // RL5 RL17
        if (sample_period_s < `CEC_SAMPLE_MIN_S) period_lim = `CEC_SAMPLE_MIN_S;
        if (sample_period_s > `CEC_SAMPLE_MAX_S) period_lim = `CEC_SAMPLE_MAX_S;
        per_next = per_reg;
        expire = 1'b0;
        if (s_tick_reg) begin
            if (per_reg >= period_lim - 32'h00000001) begin // RL5
                per_next = 32'h00000000;
                expire = 1'b1;
            end else begin
                per_next = per_reg + 32'h00000001;
            end
        end
    end
    // ------------------------------------------------------------
    // snapshots and notifications
    // ------------------------------------------------------------
    cec_counts_t sv0_reg, sv0_next, sv1_reg, sv1_next;
    logic [3:0] notify_next, changed;
    logic push_next;
    logic [1:0] lvl_reg;
    logic done_reg;
    logic [31:0] ep_unused;
    always_comb begin
        sv0_next = sv0_reg;
        sv1_next = sv1_reg;
        changed = 4'h0;
        // evaluation period attributes do not reach any timing
        ep_unused = epmin_attr ^ epmax_attr; // RL14
        if (expire) begin
            if (act[0]) sv0_next = live[0]; // RL2
            if (act[1]) sv1_next = live[1]; // RL2
            changed[0] = sv0_next.events != sv0_reg.events; // RL4
            changed[1] = sv0_next.abnormal_s != sv0_reg.abnormal_s;
            changed[2] = sv1_next.events != sv1_reg.events;
            changed[3] = sv1_next.abnormal_s != sv1_reg.abnormal_s;
        end
        notify_next = 4'h0;
        push_next = 1'b0;
        if (comm_mode == CEC_MODE_OBSERVE) begin // RL10
            notify_next = changed & observe_en; // RL13 RL16
        end else begin
            push_next = |changed; // RL10
        end
    end
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            per_reg <= 32'h00000000;
            sv0_reg <= '0;
            sv1_reg <= '0;
            notify <= 4'h0;
            push_req <= 1'b0;
            lvl_reg <= 2'h0;
            done_reg <= 1'b0;
        end else begin
            per_reg <= per_next;
            sv0_reg <= sv0_next; // RL3
            sv1_reg <= sv1_next;
            notify <= notify_next;
            push_req <= push_next;
            lvl_reg <= lvl;
            done_reg <= expire;
        end
    end
    assign saved_first = sv0_reg;
    assign saved_second = sv1_reg;
    assign level_out = lvl_reg;
    assign sample_done = done_reg;
endmodule
`default_nettype wire

// File: cec_properties.sv
// checker for cec_top: snapshot, notify and period timing
// assumes configuration held static between samples
`timescale 1ns/1ps
`default_nettype none
`include "cec_consts.svh"
module cec_properties
    import cec_pkg::*;
#(
    parameter int MS_CYCLES = 4,
    parameter int MS_PER_S = 5
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // configuration
    input wire cec_mode_t comm_mode,
    input wire logic [31:0] sample_period_s,
    input wire logic [1:0] active_sel,
    input wire logic counters_clear,
    input wire logic [3:0] observe_en,
    // results
    input wire cec_counts_t saved_first,
    input wire cec_counts_t saved_second,
    input wire logic [3:0] notify,
    input wire logic push_req,
    input wire logic sample_done
);
    // ----------------------------------------
    // helper: cycles between samples
    // ----------------------------------------
    logic [31:0] lim, gap_reg, gap_next;
    logic seen_reg, seen_next, clr_reg, clr_next;
    always_comb begin
        lim = sample_period_s;
        if (lim < `CEC_SAMPLE_MIN_S) lim = `CEC_SAMPLE_MIN_S;
        if (lim > `CEC_SAMPLE_MAX_S) lim = `CEC_SAMPLE_MAX_S;
        gap_next = sample_done ? 32'h0 : gap_reg + 32'h1;
        seen_next = seen_reg | sample_done;
        clr_next = counters_clear | (clr_reg & !sample_done);
    end
    always_ff @(posedge sys_clk) begin
        gap_reg <= rst_n ? gap_next : 32'h0;
        seen_reg <= rst_n ? seen_next : 1'b0;
        clr_reg <= rst_n ? clr_next : 1'b0;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_notify_on_sample: assert property (notify != 4'h0 |-> sample_done)
        else $error("notify outside a sample");
    a_notify_observed: assert property ((notify & ~$past(observe_en)) == 4'h0)
        else $error("notify without observation");
    a_quiet_first: assert property (notify[0] |-> $changed(saved_first.events))
        else $error("notify on unchanged first value");
    a_quiet_second: assert property (notify[2] |-> $changed(saved_second.events))
        else $error("notify on unchanged second value");
    a_change_notifies: assert property (sample_done && $changed(saved_first.events)
        && $past(observe_en[0]) && $past(comm_mode) == CEC_MODE_OBSERVE |-> notify[0])
        else $error("changed value not notified");
    a_saved_holds: assert property (!sample_done |-> $stable(saved_first) && $stable(saved_second))
        else $error("saved value moved between samples");
    a_push_gated: assert property (push_req |-> sample_done && $past(comm_mode) == CEC_MODE_PUSH)
        else $error("push request out of place");
    a_push_silent: assert property ($past(comm_mode) == CEC_MODE_PUSH |-> notify == 4'h0)
        else $error("notify in push mode");
    a_period_gap: assert property (sample_done && seen_reg |-> gap_reg == lim * MS_CYCLES * MS_PER_S - 1)
        else $error("sampling period wrong");
    a_inactive_frozen: assert property (sample_done && $past(active_sel) == `CEC_ACT_FIRST
        |-> $stable(saved_second) && !notify[2])
        else $error("inactive input refreshed");
    a_no_report_clear: assert property (sample_done && !clr_reg
        |-> saved_first.events >= $past(saved_first.events))
        else $error("count dropped without clear");
    c_notify: cover property (notify[0]);
    c_push: cover property (push_req);
    c_cleared: cover property (sample_done && clr_reg);
endmodule
`default_nettype wire

// File: cec_server_model.sv
// server model: holds observations and sends ignored attributes
// assumes one-cycle notify pulses
`timescale 1ns/1ps
`default_nettype none
module cec_server_model (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // bench control
    input wire logic wild_attr,
    // device side
    input wire logic [3:0] notify,
    output logic [3:0] observe_en,
    output logic [31:0] epmin_attr,
    output logic [31:0] epmax_attr,
    output logic [7:0] notify_count
);
    // observe both event counters only
    assign observe_en = 4'h5;
    assign epmin_attr = wild_attr ? 32'h00000001 : 32'h0;
    assign epmax_attr = wild_attr ? 32'h00000002 : 32'h0;
    always_ff @(posedge sys_clk) begin
        notify_count <= rst_n ? notify_count + 8'($countones(notify)) : 8'h00;
    end
endmodule
`default_nettype wire

// File: contact_event_counter_test.sv
// testbench for cec_top with a server model
// assumes MS_CYCLES 4 and MS_PER_S 5, one second is 20 clocks
`timescale 1ns/1ps
`default_nettype none
`include "cec_consts.svh"
module contact_event_counter_test
    import cec_pkg::*;
;
    logic sys_clk = 0, rst_n = 0, in1 = 0, in2 = 0, clr = 0, wild = 0;
    cec_mode_t mode = CEC_MODE_OBSERVE;
    logic [31:0] per = 32'h0000003C;
    logic [1:0] act = `CEC_ACT_BOTH;
    cec_chan_cfg_t c1 = '{`CEC_DET_BOTH, 32'h0000000A, 1'b1, 1'b1};
    cec_chan_cfg_t c2 = '{`CEC_DET_LOW, 32'h0000000A, 1'b0, 1'b1};
    logic [3:0] obs, notify;
    logic [31:0] emin, emax;
    logic [1:0] lvl;
    cec_counts_t s1, s2;
    logic push, done;
    logic [7:0] ncnt;
    int mismatches = 0, checked = 0;
    cec_top #(.MS_CYCLES(4), .MS_PER_S(5)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
        .contact_input_first(in1), .contact_input_second(in2), .comm_mode(mode), .sample_period_s(per),
        .active_sel(act), .cfg_first(c1), .cfg_second(c2), .counters_clear(clr), .observe_en(obs),
        .epmin_attr(emin), .epmax_attr(emax), .level_out(lvl), .saved_first(s1), .saved_second(s2),
        .notify(notify), .push_req(push), .sample_done(done));
    cec_server_model srv_u (.sys_clk(sys_clk), .rst_n(rst_n), .wild_attr(wild), .notify(notify),
        .observe_en(obs), .epmin_attr(emin), .epmax_attr(emax), .notify_count(ncnt));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic flip(input logic ch, input logic v);
        @(posedge sys_clk);
        if (ch) in2 <= v;
        else in1 <= v;
        repeat (60) @(posedge sys_clk);
    endtask
    task automatic sample();
        int i;
        i = 0;
        @(posedge sys_clk);
        #1;
        while (done !== 1'b1 && i < 1300) begin
            @(posedge sys_clk);
            #1;
            i++;
        end
        chk(done, 1);
    endtask
    task automatic results();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_count();
        sample();
        flip(1'b0, 1'b1);
        flip(1'b0, 1'b0);
        flip(1'b0, 1'b1);
        flip(1'b0, 1'b0);
        flip(1'b0, 1'b1);
        // short bounce, must be filtered out
        @(posedge sys_clk);
        in1 <= 1'b0;
        repeat (20) @(posedge sys_clk);
        in1 <= 1'b1;
        for (int k = 0; k < 4; k++) flip(1'b1, !k[0]);
        sample();
        chk(s1.events, 5);
        chk(s2.events, 2);
        chk(notify, 4'h5);
        chk(lvl, 2'h1);
    endtask
    task automatic t_quiet();
        sample();
        chk(notify, 4'h0);
        chk(s1.events, 5);
    endtask
    task automatic t_inactive();
        @(posedge sys_clk);
        act <= `CEC_ACT_FIRST;
        wild <= 1'b1;
        // clear so that a wrongly refreshed second snapshot would differ
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        flip(1'b1, 1'b1);
        flip(1'b1, 1'b0);
        flip(1'b0, 1'b0);
        sample();
        chk(s1.events, 1);
        chk(s2.events, 2);
        chk(notify, 4'h1);
    endtask
    task automatic t_push();
        @(posedge sys_clk);
        act <= `CEC_ACT_BOTH;
        mode <= CEC_MODE_PUSH;
        flip(1'b0, 1'b1);
        sample();
        chk(push, 1);
        chk(notify, 4'h0);
        chk(s1.events, 2);
    endtask
    task automatic t_clear();
        @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        sample();
        chk(s1.events, 0);
        chk(s2.events, 0);
        chk(s2.abnormal_s, 0);
        // cleared two cycles after a second tick: 59 whole seconds follow
        chk(s1.abnormal_s, 32'h0000003B);
        chk(ncnt, 3);
    endtask
    task automatic t_high();
        @(posedge sys_clk);
        act <= `CEC_ACT_SECOND;
        c2.det_type <= `CEC_DET_HIGH;
        flip(1'b1, 1'b1);
        flip(1'b1, 1'b0);
        flip(1'b0, 1'b0);
        sample();
        chk(s2.events, 1);
        // live time of the first input has moved on, its snapshot must not
        chk(s1.abnormal_s, 32'h0000003B);
        chk(s1.events, 0);
        chk(push, 1);
        chk(lvl, 2'h0);
    endtask
    initial forever #20 sys_clk = ~sys_clk;
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        results();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rst_n <= 1;
        t_count();
        t_quiet();
        t_inactive();
        t_push();
        t_clear();
        t_high();
        results();
    end
endmodule
bind cec_top cec_properties #(.MS_CYCLES(MS_CYCLES), .MS_PER_S(MS_PER_S)) prop_u (.sys_clk(sys_clk),
    .rst_n(rst_n), .comm_mode(comm_mode), .sample_period_s(sample_period_s), .active_sel(active_sel),
    .counters_clear(counters_clear), .observe_en(observe_en), .saved_first(saved_first),
    .saved_second(saved_second), .notify(notify), .push_req(push_req), .sample_done(sample_done));
`default_nettype wire
